/* File: hw/issel_regs.svh */
// issel_regs.svh: register map, field layout, reset values and selector codes
// of the interrupt source selector; assumes a 32-bit APB address space.
`ifndef ISSEL_REGS_SVH
`define ISSEL_REGS_SVH

`define ISSEL_ADDR_SEL_HIGH 32'h019C_0000
`define ISSEL_ADDR_SEL_LOW 32'h019C_0004
`define ISSEL_ADDR_POLARITY 32'h019C_0008
`define ISSEL_ADDR_PIN_ENABLE 32'h019C_000C
`define ISSEL_ADDR_PIN_DIR 32'h019C_0010
`define ISSEL_ADDR_GIE 32'h019C_0014
`define ISSEL_ADDR_GPIO_STATUS 32'h019C_0018
`define ISSEL_ADDR_GPIO_MASK 32'h019C_001C

`define ISSEL_SEL_LOW_RESET 32'h2507_18A4
`define ISSEL_SEL_HIGH_RESET 32'h0820_2D43
`define ISSEL_SEL_WMASK 32'h7FFF_7FFF
`define ISSEL_FIELD_W 5
`define ISSEL_FIELDS_PER_REG 6
`define ISSEL_PIN_LSB 4

`define ISSEL_CODE_HOST 5'h00
`define ISSEL_CODE_TIMER0 5'h01
`define ISSEL_CODE_TIMER1 5'h02
`define ISSEL_CODE_MEMIF 5'h03
`define ISSEL_CODE_GPIO4 5'h04
`define ISSEL_CODE_DMA 5'h08
`define ISSEL_CODE_EMU_XFER 5'h09
`define ISSEL_CODE_EMU_RX 5'h0A
`define ISSEL_CODE_EMU_TX 5'h0B
`define ISSEL_CODE_SER0_TX 5'h0C
`define ISSEL_CODE_SER0_RX 5'h0D
`define ISSEL_CODE_SER1_TX 5'h0E
`define ISSEL_CODE_SER1_RX 5'h0F
`define ISSEL_CODE_GPIO_ALL 5'h10
`define ISSEL_CODE_TWI0 5'h16
`define ISSEL_CODE_TWI1 5'h17
`define ISSEL_CODE_AUD0_TX 5'h1C
`define ISSEL_CODE_AUD0_RX 5'h1D
`define ISSEL_CODE_AUD1_TX 5'h1E
`define ISSEL_CODE_AUD1_RX 5'h1F

`endif

/* File: hw/issel_pkg.sv */
// issel_pkg: types shared by the interrupt source selector.
// assumes issel_regs.svh supplies the numeric constants.
package issel_pkg;

    typedef enum logic [1:0] {
        ISSEL_IDLE = 2'b01,
        ISSEL_ACCESS = 2'b10
    } issel_state_t;

    typedef logic [4:0] issel_code_t;

endpackage : issel_pkg

/* File: hw/issel_top.sv */
// issel_top: interrupt source selector with APB register slave and the
// edge logic of external pins 4-7.
// assumes peripheral events are one-cycle pulses synchronous to pclk.
//
// The APB register port was chosen for this implementation.
`include "issel_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module issel_top
    import issel_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_event,
    input wire logic nmi_event,
    input wire logic host_port_event,
    input wire logic timer_zero_event,
    input wire logic timer_one_event,
    input wire logic memory_interface_event,
    input wire logic dma_completion_event,
    input wire logic emulation_transfer_event,
    input wire logic emulation_receive_event,
    input wire logic emulation_transmit_event,
    input wire logic serial_port0_transmit_event,
    input wire logic serial_port0_receive_event,
    input wire logic serial_port1_transmit_event,
    input wire logic serial_port1_receive_event,
    input wire logic gpio_combined_event,
    input wire logic two_wire0_event,
    input wire logic two_wire1_event,
    input wire logic audio_port0_transmit_event,
    input wire logic audio_port0_receive_event,
    input wire logic audio_port1_transmit_event,
    input wire logic audio_port1_receive_event,
    input wire logic [3:0] external_interrupt_pin,
    output logic [15:0] cpu_int,
    output logic gpio_irq
);

    issel_state_t state_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] sel_high_reg;
    logic [31:0] sel_low_reg;
    logic [3:0] external_edge_polarity_reg;
    logic [3:0] gpio_pin_enable_reg;
    logic [3:0] gpio_pin_direction_reg;
    logic global_interrupt_enable_reg;
    logic [3:0] gpio_status_reg;
    logic [3:0] gpio_mask_reg;
    logic [3:0] gpio_status_next;
    logic [3:0] gpio_mask_next;
    logic gpio_irq_reg;
    logic [3:0] pin_last_reg;
    logic [3:0] gpio_event;
    logic [15:0] cpu_int_reg;
    logic [31:0] ev_vec;
    logic [11:0] line_hit;
    issel_code_t line_code [12];
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_en;
    logic [3:0] status_clr;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_int = cpu_int_reg;
    assign gpio_irq = gpio_irq_reg;

    // apb: one wait-free access phase; pready is raised from the setup edge
    assign wr_en = (state_reg == ISSEL_ACCESS) && psel && penable && pwrite && pready_reg;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `ISSEL_ADDR_SEL_HIGH: rd_data = sel_high_reg;
            `ISSEL_ADDR_SEL_LOW: rd_data = sel_low_reg;
            `ISSEL_ADDR_POLARITY: rd_data[3:0] = external_edge_polarity_reg;
            `ISSEL_ADDR_PIN_ENABLE: rd_data[7:4] = gpio_pin_enable_reg;
            `ISSEL_ADDR_PIN_DIR: rd_data[7:4] = gpio_pin_direction_reg;
            `ISSEL_ADDR_GIE: rd_data[0] = global_interrupt_enable_reg;
            `ISSEL_ADDR_GPIO_STATUS: rd_data[3:0] = gpio_status_reg;
            `ISSEL_ADDR_GPIO_MASK: rd_data[3:0] = gpio_mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ISSEL_IDLE;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            case (state_reg)
                ISSEL_IDLE: begin
                    if (psel && !penable) begin
                        state_reg <= ISSEL_ACCESS;
                        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
                        pslverr_reg <= !rd_hit;
                        pready_reg <= 1'b1;
                    end
                end
                ISSEL_ACCESS: begin
                    if (!psel || (penable && pready_reg)) begin
                        state_reg <= ISSEL_IDLE;
                        prdata_reg <= 32'h0000_0000;
                        pslverr_reg <= 1'b0;
                        pready_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ISSEL_IDLE;
                    pready_reg <= 1'b0;
                end
            endcase
        end
    end

    // selector registers; reserved bits 15 and 31 never store a one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_high_reg <= `ISSEL_SEL_HIGH_RESET;
            sel_low_reg <= `ISSEL_SEL_LOW_RESET;
        end else if (wr_en) begin
            if (paddr == `ISSEL_ADDR_SEL_HIGH)
                sel_high_reg <= pwdata & `ISSEL_SEL_WMASK;
            if (paddr == `ISSEL_ADDR_SEL_LOW)
                sel_low_reg <= pwdata & `ISSEL_SEL_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_edge_polarity_reg <= 4'h0;
            gpio_pin_enable_reg <= 4'h0;
            gpio_pin_direction_reg <= 4'h0;
            global_interrupt_enable_reg <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `ISSEL_ADDR_POLARITY: external_edge_polarity_reg <= pwdata[3:0];
                `ISSEL_ADDR_PIN_ENABLE: gpio_pin_enable_reg <= pwdata[7:4];
                `ISSEL_ADDR_PIN_DIR: gpio_pin_direction_reg <= pwdata[7:4];
                `ISSEL_ADDR_GIE: global_interrupt_enable_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // pins 4-7: an event only fires on an enabled pin configured as input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_last_reg <= 4'h0;
        else
            pin_last_reg <= external_interrupt_pin;
    end

    generate
        for (genvar p = 0; p < 4; p++) begin : g_pin
            logic rise;
            logic fall;
            assign rise = external_interrupt_pin[p] && !pin_last_reg[p];
            assign fall = !external_interrupt_pin[p] && pin_last_reg[p];
            assign gpio_event[p] = gpio_pin_enable_reg[p] && !gpio_pin_direction_reg[p]
                && (external_edge_polarity_reg[p] ? fall : rise);
        end
    endgenerate

    // gpio status: set wins over a write-one-to-clear in the same cycle
    assign status_clr = (wr_en && paddr == `ISSEL_ADDR_GPIO_STATUS) ? pwdata[3:0] : 4'h0;
    assign gpio_status_next = (gpio_status_reg & ~status_clr) | gpio_event;
    assign gpio_mask_next = (wr_en && paddr == `ISSEL_ADDR_GPIO_MASK) ? pwdata[3:0]
        : gpio_mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_status_reg <= 4'h0;
            gpio_mask_reg <= 4'h0;
            gpio_irq_reg <= 1'b0;
        end else begin
            gpio_status_reg <= gpio_status_next;
            gpio_mask_reg <= gpio_mask_next;
            gpio_irq_reg <= |(gpio_status_next & gpio_mask_next);
        end
    end

    // event table indexed by selector code; unlisted codes stay zero
    always_comb begin
        ev_vec = 32'h0000_0000;
        ev_vec[`ISSEL_CODE_HOST] = host_port_event;
        ev_vec[`ISSEL_CODE_TIMER0] = timer_zero_event;
        ev_vec[`ISSEL_CODE_TIMER1] = timer_one_event;
        ev_vec[`ISSEL_CODE_MEMIF] = memory_interface_event;
        ev_vec[`ISSEL_CODE_GPIO4 +: 4] = gpio_event;
        ev_vec[`ISSEL_CODE_DMA] = dma_completion_event;
        ev_vec[`ISSEL_CODE_EMU_XFER] = emulation_transfer_event;
        ev_vec[`ISSEL_CODE_EMU_RX] = emulation_receive_event;
        ev_vec[`ISSEL_CODE_EMU_TX] = emulation_transmit_event;
        ev_vec[`ISSEL_CODE_SER0_TX] = serial_port0_transmit_event;
        ev_vec[`ISSEL_CODE_SER0_RX] = serial_port0_receive_event;
        ev_vec[`ISSEL_CODE_SER1_TX] = serial_port1_transmit_event;
        ev_vec[`ISSEL_CODE_SER1_RX] = serial_port1_receive_event;
        ev_vec[`ISSEL_CODE_GPIO_ALL] = gpio_combined_event;
        ev_vec[`ISSEL_CODE_TWI0] = two_wire0_event;
        ev_vec[`ISSEL_CODE_TWI1] = two_wire1_event;
        ev_vec[`ISSEL_CODE_AUD0_TX] = audio_port0_transmit_event;
        ev_vec[`ISSEL_CODE_AUD0_RX] = audio_port0_receive_event;
        ev_vec[`ISSEL_CODE_AUD1_TX] = audio_port1_transmit_event;
        ev_vec[`ISSEL_CODE_AUD1_RX] = audio_port1_receive_event;
    end

    // field slots 3-5 skip bit 15/31, hence the extra one on the lsb
    generate
        for (genvar k = 0; k < 12; k++) begin : g_line
            localparam int SLOT = k % `ISSEL_FIELDS_PER_REG;
            localparam int LSB = SLOT * `ISSEL_FIELD_W + ((SLOT >= 3) ? 1 : 0);
            assign line_code[k] = (k < `ISSEL_FIELDS_PER_REG)
                ? sel_low_reg[LSB +: `ISSEL_FIELD_W]
                : sel_high_reg[LSB +: `ISSEL_FIELD_W];
            assign line_hit[k] = global_interrupt_enable_reg && ev_vec[line_code[k]];
        end
    endgenerate

    // bit index is the priority: the core serves bit 0 first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_int_reg <= 16'h0000;
        end else begin
            cpu_int_reg[0] <= reset_event;
            cpu_int_reg[1] <= nmi_event;
            cpu_int_reg[3:2] <= 2'b00;
            cpu_int_reg[15:4] <= line_hit;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    fixed_lines_a: assert property (
        cpu_int_reg[3:2] == 2'b00 && cpu_int_reg[1] == $past(nmi_event)
        && cpu_int_reg[0] == $past(reset_event))
        else $error("fixed interrupt lines wrong");

    gie_blocks_a: assert property (
        !global_interrupt_enable_reg |=> cpu_int_reg[15:4] == 12'h000)
        else $error("maskable line asserted with global enable clear");

    line_forward_a: assert property (
        global_interrupt_enable_reg && ev_vec[line_code[11]] |=> cpu_int_reg[15])
        else $error("selected event not forwarded on line 15");

    line_quiet_a: assert property (
        !ev_vec[line_code[0]] |=> !cpu_int_reg[4])
        else $error("line 4 asserted without its selected event");

    reserved_code_a: assert property (
        (line_code[0] inside {[5'h11:5'h15], [5'h18:5'h1B]}) |=> !cpu_int_reg[4])
        else $error("reserved selector code asserted a line");

    sel_write_a: assert property (
        wr_en && paddr == `ISSEL_ADDR_SEL_HIGH
        |=> sel_high_reg == ($past(pwdata) & `ISSEL_SEL_WMASK))
        else $error("high selector write not taken");

    rsvd_read_a: assert property (
        pready_reg && !pslverr_reg |-> prdata_reg[31] == 1'b0 && prdata_reg[15] == 1'b0)
        else $error("reserved selector bit read as one");

    pin_edge_a: assert property (
        gpio_pin_enable_reg[0] && !gpio_pin_direction_reg[0] && external_edge_polarity_reg[0]
        && !external_interrupt_pin[0] && pin_last_reg[0] |=> gpio_status_reg[0])
        else $error("falling edge on pin 4 not latched");

    gpio_irq_a: assert property (
        gpio_irq_reg == |(gpio_status_reg & gpio_mask_reg))
        else $error("gpio interrupt output disagrees with status and mask");

    apb_ready_a: assert property (
        pready_reg |=> !pready_reg)
        else $error("pready held longer than one cycle");

    sel_low_write_a: assert property (
        wr_en && paddr == `ISSEL_ADDR_SEL_LOW
        |=> sel_low_reg == ($past(pwdata) & `ISSEL_SEL_WMASK))
        else $error("low selector write not taken");

    sel_read_a: assert property (
        state_reg == ISSEL_IDLE && psel && !penable && !pwrite
        && paddr == `ISSEL_ADDR_SEL_LOW |=> prdata_reg == $past(sel_low_reg))
        else $error("low selector read data wrong");

    setup_ready_a: assert property (
        state_reg == ISSEL_IDLE && psel && !penable |=> pready_reg)
        else $error("no ready in the access phase");

    unmapped_err_a: assert property (
        state_reg == ISSEL_IDLE && psel && !penable && !rd_hit
        |=> pslverr_reg && prdata_reg == 32'h0000_0000)
        else $error("unmapped access not refused");

    rsvd_bits_zero_a: assert property (
        !sel_high_reg[15] && !sel_high_reg[31] && !sel_low_reg[15] && !sel_low_reg[31])
        else $error("reserved selector bit stored a one");

    line_forward_low_a: assert property (
        global_interrupt_enable_reg && ev_vec[line_code[0]] |=> cpu_int_reg[4])
        else $error("selected event not forwarded on line 4");

    line_quiet_high_a: assert property (
        !ev_vec[line_code[11]] |=> !cpu_int_reg[15])
        else $error("line 15 asserted without its selected event");

    reserved_high_a: assert property (
        (line_code[11] inside {[5'h11:5'h15], [5'h18:5'h1B]}) |=> !cpu_int_reg[15])
        else $error("reserved selector code asserted line 15");

    pin_rise_a: assert property (
        gpio_pin_enable_reg[0] && !gpio_pin_direction_reg[0] && !external_edge_polarity_reg[0]
        && external_interrupt_pin[0] && !pin_last_reg[0] |=> gpio_status_reg[0])
        else $error("rising edge on pin 4 not latched");

    pin_blocked_a: assert property (
        !gpio_pin_enable_reg[0] || gpio_pin_direction_reg[0] |-> !gpio_event[0])
        else $error("event from a disabled or output pin");

    status_clear_a: assert property (
        wr_en && paddr == `ISSEL_ADDR_GPIO_STATUS && pwdata[0] && !gpio_event[0]
        |=> !gpio_status_reg[0])
        else $error("gpio status bit not cleared by a one");

    status_hold_a: assert property (
        gpio_event == 4'h0 && !(wr_en && paddr == `ISSEL_ADDR_GPIO_STATUS)
        |=> $stable(gpio_status_reg))
        else $error("gpio status changed without event or clear");

endmodule : issel_top

`default_nettype wire

/* File: test/issel_far_end.sv */
// issel_far_end: behavioural event sources and general-purpose pins 4-7
// assumes fire is raised for one cycle by the bench just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module issel_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [4:0] code,
    output logic [31:0] ev,
    output logic [3:0] pin
);
    // events are one-cycle pulses; a pin toggles its level, so only one polarity sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev <= 32'h0000_0000;
            pin <= 4'h0;
        end else begin
            ev <= 32'h0000_0000;
            if (fire && (code < 5'h04 || code > 5'h07)) begin
                ev[code] <= 1'b1;
            end
            if (fire && code >= 5'h04 && code <= 5'h07) begin
                pin[code[1:0]] <= ~pin[code[1:0]];
            end
        end
    end
endmodule : issel_far_end
`default_nettype wire

/* File: test/test_interrupt_source_selector.sv */
// test_interrupt_source_selector: apb master, event driver and result queues
// assumes issel_far_end drives the peripheral event and pin inputs of the selector; the bench drives reset_event and nmi_event
`include "issel_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_source_selector;
    localparam logic [31:0] zero = 32'h0000_0000;
    logic pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, gpio_irq, global_interrupt_enable;
    logic [31:0] paddr, pwdata, prdata, ev, sel_lo, sel_hi, seed;
    logic [15:0] cpu_int;
    logic [4:0] code;
    logic [3:0] pin, pol, lvl;
    logic [1:0] fixed;
    logic [15:0] ev_q[$];
    logic [33:0] xfer_q[$];
    int slot[6] = '{0, 5, 10, 16, 21, 26};
    int fail_count = 0;
    int n_checks = 0;

    issel_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_event(fixed[0]), .nmi_event(fixed[1]),
        .host_port_event(ev[0]), .timer_zero_event(ev[1]), .timer_one_event(ev[2]),
        .memory_interface_event(ev[3]), .dma_completion_event(ev[8]),
        .emulation_transfer_event(ev[9]), .emulation_receive_event(ev[10]),
        .emulation_transmit_event(ev[11]), .serial_port0_transmit_event(ev[12]),
        .serial_port0_receive_event(ev[13]), .serial_port1_transmit_event(ev[14]),
        .serial_port1_receive_event(ev[15]), .gpio_combined_event(ev[16]),
        .two_wire0_event(ev[22]), .two_wire1_event(ev[23]),
        .audio_port0_transmit_event(ev[28]), .audio_port0_receive_event(ev[29]),
        .audio_port1_transmit_event(ev[30]), .audio_port1_receive_event(ev[31]),
        .external_interrupt_pin(pin), .cpu_int(cpu_int), .gpio_irq(gpio_irq));
    issel_far_end i_far (.pclk(pclk), .presetn(presetn), .fire(fire), .code(code),
        .ev(ev), .pin(pin));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // lines expected for one event; a pin counts only if its toggle matches the polarity
    function automatic logic [15:0] exp_lines(input logic [4:0] c);
        logic [15:0] v;
        logic [31:0] r;
        v = 16'h0000;
        for (int n = 4; n < 16; n++) begin
            r = (n < 10) ? sel_lo >> slot[n - 4] : sel_hi >> slot[n - 10];
            if (global_interrupt_enable && r[4:0] == c && !(c inside {[5'h11:5'h15], [5'h18:5'h1B]})
                && !(c inside {[5'h04:5'h07]} && pol[c[1:0]] != lvl[c[1:0]])) begin
                v[n] = 1'b1;
            end
        end
        return v;
    endfunction : exp_lines

    task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : compare

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        input logic [31:0] ed, input logic ee);
        xfer_q.push_back({ee, ~wr, ed});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic fire_code(input logic [4:0] c);
        logic [15:0] e;
        e = exp_lines(c);
        if (e !== 16'h0000) ev_q.push_back(e);
        if (c inside {[5'h04:5'h07]}) lvl[c[1:0]] = ~lvl[c[1:0]];
        fire <= 1'b1;
        code <= c;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : fire_code

    task automatic pulse_fixed(input logic [1:0] f);
        ev_q.push_back({14'h0000, f});
        fixed <= f;
        @(posedge pclk);
        fixed <= 2'b00;
        repeat (6) @(posedge pclk);
    endtask : pulse_fixed

    task automatic gpio_case(input logic m);
        pol[0] = lvl[0];
        apb(1'b1, `ISSEL_ADDR_POLARITY, {28'h000_0000, pol}, zero, 1'b0);
        fire_code(`ISSEL_CODE_GPIO4);
        compare("gpio_irq", {31'h0000_0000, m}, {31'h0000_0000, gpio_irq});
        apb(1'b0, `ISSEL_ADDR_GPIO_STATUS, zero, 32'h0000_0001, 1'b0);
    endtask : gpio_case

    always @(posedge pclk) begin
        logic [33:0] xf;
        logic [15:0] ex;
        if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
            xf = xfer_q.pop_front();
            compare("pslverr", {31'h0000_0000, xf[33]}, {31'h0000_0000, pslverr});
            if (xf[32]) compare("prdata", xf[31:0], prdata);
        end
        if (presetn === 1'b1 && cpu_int !== 16'h0000) begin
            ex = (ev_q.size() > 0) ? ev_q.pop_front() : 16'h0000;
            compare("cpu_int", {16'h0000, ex}, {16'h0000, cpu_int});
        end
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #200000;
        fail_count++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, fire, fixed, global_interrupt_enable, pol, lvl} = '0;
        {paddr, pwdata, code} = '0;
        seed = 32'h0000_0011;
        sel_lo = `ISSEL_SEL_LOW_RESET;
        sel_hi = `ISSEL_SEL_HIGH_RESET;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ISSEL_ADDR_SEL_LOW, zero, `ISSEL_SEL_LOW_RESET, 1'b0);
        apb(1'b0, `ISSEL_ADDR_SEL_HIGH, zero, `ISSEL_SEL_HIGH_RESET, 1'b0);
        apb(1'b1, 32'h019C_0020, 32'hFFFF_FFFF, zero, 1'b1);
        apb(1'b0, 32'h019C_0020, zero, zero, 1'b1);
        fire_code(`ISSEL_CODE_TIMER0);
        pulse_fixed(2'b01);
        pulse_fixed(2'b10);
        apb(1'b1, `ISSEL_ADDR_GIE, 32'h0000_0001, zero, 1'b0);
        global_interrupt_enable = 1'b1;
        apb(1'b1, `ISSEL_ADDR_PIN_ENABLE, 32'h0000_00F0, zero, 1'b0);
        apb(1'b1, `ISSEL_ADDR_PIN_DIR, zero, zero, 1'b0);
        for (int k = 0; k < 64; k++) begin
            if (k == 32) begin
                // line 4 gets a reserved code so its refusal is exercised
                seed = lfsr(seed);
                seed = {seed[31:5], 5'h11};
                sel_lo = seed & `ISSEL_SEL_WMASK;
                apb(1'b1, `ISSEL_ADDR_SEL_LOW, seed, zero, 1'b0);
                seed = lfsr(seed);
                sel_hi = seed & `ISSEL_SEL_WMASK;
                pol = seed[3:0];
                apb(1'b1, `ISSEL_ADDR_POLARITY, {28'h000_0000, pol}, zero, 1'b0);
                apb(1'b1, `ISSEL_ADDR_SEL_HIGH, seed, zero, 1'b0);
            end
            fire_code(k[4:0]);
            if (k == 32) apb(1'b0, `ISSEL_ADDR_SEL_LOW, zero, sel_lo, 1'b0);
            if (k == 32) apb(1'b0, `ISSEL_ADDR_SEL_HIGH, zero, sel_hi, 1'b0);
        end
        apb(1'b1, `ISSEL_ADDR_GPIO_STATUS, 32'h0000_000F, zero, 1'b0);
        apb(1'b1, `ISSEL_ADDR_GPIO_MASK, 32'h0000_0001, zero, 1'b0);
        apb(1'b0, `ISSEL_ADDR_GPIO_STATUS, zero, zero, 1'b0);
        gpio_case(1'b1);
        apb(1'b1, `ISSEL_ADDR_GPIO_STATUS, 32'h0000_0001, zero, 1'b0);
        @(negedge pclk);
        compare("gpio_irq", zero, {31'h0000_0000, gpio_irq});
        apb(1'b1, `ISSEL_ADDR_GPIO_MASK, zero, zero, 1'b0);
        gpio_case(1'b0);
        repeat (4) @(posedge pclk);
        compare("missed events", zero, 32'(ev_q.size()));
        summarize();
    end
endmodule : test_interrupt_source_selector
`default_nettype wire
